// ==== pkg/radio_ctrl_defines.vh ====
// constants for the baseband filter, gain and mux control block
`ifndef RADIO_CTRL_DEFINES_VH
`define RADIO_CTRL_DEFINES_VH

// ------------------------------------------------------------
// serial word layout: 14 data bits then 4 address bits
// ------------------------------------------------------------
`define SER_WORD_BITS 18
`define SER_DATA_BITS 14
`define SER_COUNT_MAX 5'h1f

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define ADDR_FILTER_TRIM_HP 4'h7
`define ADDR_FILTER_MODE_MUX 4'h8
`define ADDR_TX_GAIN_SOURCE 4'h9
`define ADDR_RX_GAIN_SETTING 4'hb
`define ADDR_TX_GAIN_SETTING 4'hc
`define ADDR_RX_OUTPUT_CM 4'hf

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_FILTER_TRIM_HP 14'h0012
`define RST_FILTER_MODE_MUX 14'h0001
`define RST_TX_GAIN_SOURCE 14'h0000
`define RST_RX_GAIN_SETTING 14'h0000
`define RST_TX_GAIN_SETTING 14'h0000
`define RST_RX_OUTPUT_CM 14'h0000

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define F_HP_CORNER_HI 13
`define F_HP_CORNER_LO 12
`define F_RX_TRIM_HI 2
`define F_RX_TRIM_LO 0
`define F_TX_TRIM_HI 5
`define F_TX_TRIM_LO 3
`define F_LPF_MODE_HI 1
`define F_LPF_MODE_LO 0
`define F_STR_SRC_HI 9
`define F_STR_SRC_LO 8
`define F_STR_GATE 10
`define F_RX_GAIN_SERIAL 12
`define F_TX_GAIN_SERIAL 10
`define F_TX_GAIN_HI 5
`define F_TX_GAIN_LO 0
`define F_CM_HI 11
`define F_CM_LO 10
`define F_LNA_HI 6
`define F_LNA_LO 5
`define F_VGA_HI 4
`define F_VGA_LO 0

// ------------------------------------------------------------
// highpass corner selections and their frequencies in Hz
// ------------------------------------------------------------
`define HP_SEL_100HZ 2'h0
`define HP_SEL_4KHZ 2'h1
`define HP_SEL_30KHZ 2'h2
`define HP_SEL_600KHZ 2'h3
`define HP_HZ_100 20'h00064
`define HP_HZ_4K 20'h00fa0
`define HP_HZ_30K 20'h07530
`define HP_HZ_600K 20'h927c0

// ------------------------------------------------------------
// strength mux sources
// ------------------------------------------------------------
`define STR_SRC_SIGNAL 2'h0
`define STR_SRC_TEMP 2'h1
`define STR_SRC_POWER 2'h2

// ------------------------------------------------------------
// lowpass corners in units of 100 kHz, trim in percent
// ------------------------------------------------------------
`define RX_LPF_11B 8'h4b
`define RX_LPF_11G 8'h55
`define RX_LPF_TURBO1 8'h96
`define RX_LPF_TURBO2 8'hb4
`define TX_LPF_11B 8'h50
`define TX_LPF_11G 8'h6e
`define TX_LPF_TURBO1 8'ha5
`define TX_LPF_TURBO2 8'he1
`define TRIM_BASE_PCT 7'h5a
`define TRIM_STEP_PCT 7'h05
`define TRIM_NOMINAL_PCT 7'h64
`define RX_TRIM_MAX 3'h4
`define TX_TRIM_MAX 3'h5

// ------------------------------------------------------------
// output common mode in mV
// ------------------------------------------------------------
`define CM_BASE_MV 11'h44c
`define CM_STEP_MV 11'h064

// ------------------------------------------------------------
// transmit gain code: fine region and step counts in 0.5 dB
// ------------------------------------------------------------
`define TXG_CODE_MAX 6'h3f
`define TXG_FINE_LOW 6'h30
`define TXG_COARSE_TOP 6'h2f
`define TXG_COARSE_BASE 7'h10

`endif

// ==== src/serial_word_rx.v ====
// three-wire serial word receiver, sampled on the system clock
`default_nettype none
`include "radio_ctrl_defines.vh"

module serial_word_rx (
   input wire clk,
   input wire rst,
   input wire sel_n,
   input wire sclk,
   input wire sdata,
   output reg word_valid,
   output reg [3:0] word_addr,
   output reg [13:0] word_data
);

reg sclk_prev;
reg sel_prev;
reg [17:0] shift;
reg [4:0] count;

wire sclk_rise = sclk & ~sclk_prev;
wire sel_rise = sel_n & ~sel_prev;

// a frame of the wrong length is dropped rather than half applied
always @(posedge clk) begin
   if (rst) begin
      sclk_prev <= 1'b0;
      sel_prev <= 1'b1;
      shift <= 18'h00000;
      count <= 5'h00;
      word_valid <= 1'b0;
      word_addr <= 4'h0;
      word_data <= 14'h0000;
   end else begin
      sclk_prev <= sclk;
      sel_prev <= sel_n;
      word_valid <= 1'b0;
      if (sel_n) begin
         count <= 5'h00;
      end else if (sclk_rise) begin
         shift <= {shift[16:0], sdata};
         if (count != `SER_COUNT_MAX) begin
            count <= count + 5'h01;
         end
      end
      if (sel_rise && count == `SER_WORD_BITS) begin // R18
         word_valid <= 1'b1;
         word_data <= shift[17:4];
         word_addr <= shift[3:0];
      end
   end
end

endmodule
`default_nettype wire

// ==== src/tx_gain_decode.v ====
// transmit gain code to attenuation below maximum, in 0.5 dB units
`default_nettype none
`include "radio_ctrl_defines.vh"

module tx_gain_decode (
   input wire [5:0] code,
   output reg [6:0] atten_half_db
);

reg [5:0] below;

always @* begin
   below = 6'h00;
   if (code >= `TXG_FINE_LOW) begin
      atten_half_db = {1'b0, `TXG_CODE_MAX - code}; // R13
   end else begin
      // code pairs share one setting, 1 dB per pair
      below = `TXG_COARSE_TOP - code;
      atten_half_db = `TXG_COARSE_BASE + {1'b0, below[5:1], 1'b0}; // R14
   end
end

endmodule
`default_nettype wire

// ==== src/radio_filter_gain_mux_control.v ====
// baseband filter, gain source and strength mux control decode
//
// Behaviour
// R01 - coupling select high forces 600 kHz highpass
// R02 - otherwise highpass corner from field, default 100Hz
// R03 - mode field picks receive lowpass coarse corner
// R04 - receive trim 90 to 110 percent, rest undefined
// R05 - common-mode field sets 1.1V up to 1.4V
// R06 - source field selects strength, temperature or power
// R07 - gate bit ties strength output to coupling select
// R08 - signal strength only driven in receive mode
// R09 - transmit only with select high and shutdown-bar high
// R10 - receive only with select low, shutdown-bar high
// R11 - same mode field picks transmit lowpass corner
// R12 - transmit trim 90 to 115 percent, rest unused
// R13 - six-bit gain code, half dB top steps
// R14 - lower gain codes pair up in 1 dB steps
// R15 - gain source bit: pins or register field
// R16 - receive gain source bit: pins or register
// R17 - registers hold; decode follows changes directly
// R18 - controller writes registers by address over serial port
`default_nettype none
`include "radio_ctrl_defines.vh"

module radio_filter_gain_mux_control (
   input wire REF_CLK,
   input wire RESET,
   input wire SER_SEL_N,
   input wire SER_CLK,
   input wire SER_DATA,
   input wire COUPLING_SELECT,
   input wire TX_RX_SELECT,
   input wire SHUTDOWN_BAR,
   input wire [5:0] PARALLEL_GAIN_PINS,
   input wire [6:0] RX_GAIN_PINS,
   output reg WRITE_DONE,
   output reg TX_EN,
   output reg RX_EN,
   output reg [1:0] HP_CORNER_SEL,
   output reg [19:0] HP_CORNER_HZ,
   output reg [7:0] RX_LPF_CORNER,
   output reg [6:0] RX_LPF_TRIM_PCT,
   output reg RX_LPF_TRIM_VALID,
   output reg [7:0] TX_LPF_CORNER,
   output reg [6:0] TX_LPF_TRIM_PCT,
   output reg TX_LPF_TRIM_VALID,
   output reg [10:0] RX_CM_MV,
   output reg [1:0] STRENGTH_SRC,
   output reg STRENGTH_ON,
   output reg [5:0] TX_GAIN_CODE,
   output reg [6:0] TX_ATTEN_HALF_DB,
   output reg [1:0] RX_LNA_GAIN,
   output reg [4:0] RX_VGA_GAIN
);

// ------------------------------------------------------------
// functions
// ------------------------------------------------------------
// out-of-range trim codes fall back to nominal so the corner stays sane
function [6:0] trim_pct;
   input [2:0] code;
   input [2:0] max_code;
   begin
      if (code <= max_code) begin
         trim_pct = `TRIM_BASE_PCT + `TRIM_STEP_PCT * {4'h0, code};
      end else begin
         trim_pct = `TRIM_NOMINAL_PCT;
      end
   end
endfunction

function [7:0] lpf_corner;
   input [1:0] mode;
   input tx_path;
   begin
      case (mode)
         2'h0: lpf_corner = tx_path ? `TX_LPF_11B : `RX_LPF_11B;
         2'h1: lpf_corner = tx_path ? `TX_LPF_11G : `RX_LPF_11G;
         2'h2: lpf_corner = tx_path ? `TX_LPF_TURBO1 : `RX_LPF_TURBO1;
         default: lpf_corner = tx_path ? `TX_LPF_TURBO2 : `RX_LPF_TURBO2;
      endcase
   end
endfunction

// ------------------------------------------------------------
// serial port
// ------------------------------------------------------------
wire word_valid;
wire [3:0] word_addr;
wire [13:0] word_data;

serial_word_rx u_rx (
   .clk(REF_CLK),
   .rst(RESET),
   .sel_n(SER_SEL_N),
   .sclk(SER_CLK),
   .sdata(SER_DATA),
   .word_valid(word_valid),
   .word_addr(word_addr),
   .word_data(word_data)
);

// ------------------------------------------------------------
// register file
// ------------------------------------------------------------
reg [13:0] filter_trim_and_highpass;
reg [13:0] filter_mode_and_output_mux;
reg [13:0] tx_gain_source_config;
reg [13:0] rx_gain_setting;
reg [13:0] tx_gain_setting;
reg [13:0] rx_output_common_mode;
reg write_hit;

// unknown addresses belong to other blocks and are left alone
// each register keeps its value until a frame addresses it
always @(posedge REF_CLK) begin
   if (RESET) begin
      filter_trim_and_highpass <= `RST_FILTER_TRIM_HP;
      filter_mode_and_output_mux <= `RST_FILTER_MODE_MUX;
      tx_gain_source_config <= `RST_TX_GAIN_SOURCE;
      rx_gain_setting <= `RST_RX_GAIN_SETTING;
      tx_gain_setting <= `RST_TX_GAIN_SETTING;
      rx_output_common_mode <= `RST_RX_OUTPUT_CM;
      write_hit <= 1'b0;
   end else begin
      write_hit <= 1'b0;
      if (word_valid) begin
         case (word_addr) // R18
            `ADDR_FILTER_TRIM_HP: begin
               filter_trim_and_highpass <= word_data; // R17
               write_hit <= 1'b1;
            end
            `ADDR_FILTER_MODE_MUX: begin
               filter_mode_and_output_mux <= word_data; // R17
               write_hit <= 1'b1;
            end
            `ADDR_TX_GAIN_SOURCE: begin
               tx_gain_source_config <= word_data; // R17
               write_hit <= 1'b1;
            end
            `ADDR_RX_GAIN_SETTING: begin
               rx_gain_setting <= word_data; // R17
               write_hit <= 1'b1;
            end
            `ADDR_TX_GAIN_SETTING: begin
               tx_gain_setting <= word_data; // R17
               write_hit <= 1'b1;
            end
            `ADDR_RX_OUTPUT_CM: begin
               rx_output_common_mode <= word_data; // R17
               write_hit <= 1'b1;
            end
            default: begin
               write_hit <= 1'b0;
            end
         endcase
      end
   end
end

// ------------------------------------------------------------
// field extraction
// ------------------------------------------------------------
wire [1:0] hp_field =
   filter_trim_and_highpass[`F_HP_CORNER_HI:`F_HP_CORNER_LO];
wire [2:0] rx_trim =
   filter_trim_and_highpass[`F_RX_TRIM_HI:`F_RX_TRIM_LO];
wire [2:0] tx_trim =
   filter_trim_and_highpass[`F_TX_TRIM_HI:`F_TX_TRIM_LO];
wire [1:0] lpf_mode =
   filter_mode_and_output_mux[`F_LPF_MODE_HI:`F_LPF_MODE_LO];
wire [1:0] str_src =
   filter_mode_and_output_mux[`F_STR_SRC_HI:`F_STR_SRC_LO];
wire str_gate = filter_mode_and_output_mux[`F_STR_GATE];
wire rx_gain_serial = filter_mode_and_output_mux[`F_RX_GAIN_SERIAL];
wire tx_gain_serial = tx_gain_source_config[`F_TX_GAIN_SERIAL];
wire [1:0] cm_code = rx_output_common_mode[`F_CM_HI:`F_CM_LO];

// ------------------------------------------------------------
// operating mode
// ------------------------------------------------------------
wire next_tx_en = TX_RX_SELECT & SHUTDOWN_BAR; // R09
wire next_rx_en = ~TX_RX_SELECT & SHUTDOWN_BAR; // R10

// ------------------------------------------------------------
// highpass corner
// ------------------------------------------------------------
reg [1:0] next_hp_sel;
reg [19:0] next_hp_hz;

// bit 12 wins over bit 13, so code 11 gives the 4 kHz corner
always @* begin
   if (COUPLING_SELECT) begin
      next_hp_sel = `HP_SEL_600KHZ; // R01
   end else if (hp_field[0]) begin
      next_hp_sel = `HP_SEL_4KHZ; // R02
   end else if (hp_field[1]) begin
      next_hp_sel = `HP_SEL_30KHZ; // R02
   end else begin
      next_hp_sel = `HP_SEL_100HZ; // R02
   end
   case (next_hp_sel)
      `HP_SEL_100HZ: next_hp_hz = `HP_HZ_100;
      `HP_SEL_4KHZ: next_hp_hz = `HP_HZ_4K;
      `HP_SEL_30KHZ: next_hp_hz = `HP_HZ_30K;
      default: next_hp_hz = `HP_HZ_600K;
   endcase
end

// ------------------------------------------------------------
// strength output mux
// ------------------------------------------------------------
reg next_str_on;

// gate bit set: output held off while coupling select is low; clear: source and mode alone decide
always @* begin
   next_str_on = 1'b1;
   if (str_gate && !COUPLING_SELECT) begin
      next_str_on = 1'b0; // R07
   end
   case (str_src) // R06
      `STR_SRC_SIGNAL: begin
         if (!next_rx_en) begin
            next_str_on = 1'b0; // R08
         end
      end
      `STR_SRC_TEMP: begin
         // temperature reading has no mode restriction
      end
      `STR_SRC_POWER: begin
         // power reading has no mode restriction
      end
      default: begin
         // undefined source code drives nothing
         next_str_on = 1'b0;
      end
   endcase
end

// ------------------------------------------------------------
// gain sources
// ------------------------------------------------------------
wire [5:0] next_tx_gain = tx_gain_serial ?
   tx_gain_setting[`F_TX_GAIN_HI:`F_TX_GAIN_LO] :
   PARALLEL_GAIN_PINS; // R15
wire [6:0] atten_half_db;

tx_gain_decode u_gain (
   .code(next_tx_gain),
   .atten_half_db(atten_half_db)
);

wire [1:0] next_lna = rx_gain_serial ?
   rx_gain_setting[`F_LNA_HI:`F_LNA_LO] : RX_GAIN_PINS[6:5]; // R16
wire [4:0] next_vga = rx_gain_serial ?
   rx_gain_setting[`F_VGA_HI:`F_VGA_LO] : RX_GAIN_PINS[4:0]; // R16

// ------------------------------------------------------------
// common mode
// ------------------------------------------------------------
wire [10:0] next_cm_mv =
   `CM_BASE_MV + `CM_STEP_MV * {9'h000, cm_code}; // R05

// ------------------------------------------------------------
// output registers: write strobe and operating mode
// ------------------------------------------------------------
// one register stage so every setting changes on a clean edge;
// pins and fields reach the outputs one cycle later, no commit
always @(posedge REF_CLK) begin
   if (RESET) begin
      WRITE_DONE <= 1'b0;
      TX_EN <= 1'b0;
      RX_EN <= 1'b0;
   end else begin
      WRITE_DONE <= write_hit;
      TX_EN <= next_tx_en; // R09
      RX_EN <= next_rx_en; // R10
   end
end

// ------------------------------------------------------------
// output registers: filter corners, trims and common mode
// ------------------------------------------------------------
// reset shows what the register reset values decode to, except
// the highpass, which starts wide until the pins are trusted
always @(posedge REF_CLK) begin
   if (RESET) begin
      HP_CORNER_SEL <= `HP_SEL_600KHZ;
      HP_CORNER_HZ <= `HP_HZ_600K;
      RX_LPF_CORNER <= `RX_LPF_11G;
      RX_LPF_TRIM_PCT <= `TRIM_NOMINAL_PCT;
      RX_LPF_TRIM_VALID <= 1'b1;
      TX_LPF_CORNER <= `TX_LPF_11G;
      TX_LPF_TRIM_PCT <= `TRIM_NOMINAL_PCT;
      TX_LPF_TRIM_VALID <= 1'b1;
      RX_CM_MV <= `CM_BASE_MV;
   end else begin
      HP_CORNER_SEL <= next_hp_sel; // R17
      HP_CORNER_HZ <= next_hp_hz;
      RX_LPF_CORNER <= lpf_corner(lpf_mode, 1'b0); // R03
      RX_LPF_TRIM_PCT <= trim_pct(rx_trim, `RX_TRIM_MAX); // R04
      RX_LPF_TRIM_VALID <= (rx_trim <= `RX_TRIM_MAX); // R04
      TX_LPF_CORNER <= lpf_corner(lpf_mode, 1'b1); // R11
      TX_LPF_TRIM_PCT <= trim_pct(tx_trim, `TX_TRIM_MAX); // R12
      TX_LPF_TRIM_VALID <= (tx_trim <= `TX_TRIM_MAX); // R12
      RX_CM_MV <= next_cm_mv;
   end
end

// ------------------------------------------------------------
// output registers: strength mux
// ------------------------------------------------------------
// held off in reset: the mode pins may not be valid yet, and a
// strength reading in the wrong mode would mislead the controller
always @(posedge REF_CLK) begin
   if (RESET) begin
      STRENGTH_SRC <= `STR_SRC_SIGNAL;
      STRENGTH_ON <= 1'b0;
   end else begin
      STRENGTH_SRC <= str_src;
      STRENGTH_ON <= next_str_on;
   end
end

// ------------------------------------------------------------
// output registers: gain selections
// ------------------------------------------------------------
// code and attenuation come from one selection in the same cycle,
// so a pin change never shows a code with the old attenuation;
// reset shows code zero, the weakest setting
always @(posedge REF_CLK) begin
   if (RESET) begin
      TX_GAIN_CODE <= 6'h00;
      TX_ATTEN_HALF_DB <= 7'h3e;
      RX_LNA_GAIN <= 2'h0;
      RX_VGA_GAIN <= 5'h00;
   end else begin
      TX_GAIN_CODE <= next_tx_gain;
      TX_ATTEN_HALF_DB <= atten_half_db; // R13
      RX_LNA_GAIN <= next_lna;
      RX_VGA_GAIN <= next_vga;
   end
end

endmodule
`default_nettype wire

// ==== test/radio_ctrl_monitor.sv ====
// port-level assertions for the filter, gain and mux control block
`default_nettype none
module radio_ctrl_monitor (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic SER_SEL_N,
   input wire logic COUPLING_SELECT,
   input wire logic TX_RX_SELECT,
   input wire logic SHUTDOWN_BAR,
   input wire logic WRITE_DONE,
   input wire logic TX_EN,
   input wire logic RX_EN,
   input wire logic [1:0] HP_CORNER_SEL,
   input wire logic [19:0] HP_CORNER_HZ,
   input wire logic [7:0] RX_LPF_CORNER,
   input wire logic [6:0] RX_LPF_TRIM_PCT,
   input wire logic RX_LPF_TRIM_VALID,
   input wire logic [7:0] TX_LPF_CORNER,
   input wire logic [6:0] TX_LPF_TRIM_PCT,
   input wire logic TX_LPF_TRIM_VALID,
   input wire logic [10:0] RX_CM_MV,
   input wire logic [1:0] STRENGTH_SRC,
   input wire logic STRENGTH_ON,
   input wire logic [5:0] TX_GAIN_CODE,
   input wire logic [6:0] TX_ATTEN_HALF_DB
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [6:0] exp_att;
   // upper codes step half a dB, lower codes pair up in whole dB
   always_comb begin
      if (TX_GAIN_CODE >= 6'h30) exp_att = 7'h3f - {1'b0, TX_GAIN_CODE};
      else exp_att = 7'h10 + {(6'h2f - TX_GAIN_CODE) >> 1, 1'b0};
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   chk_tx_enable: assert property (!$past(RESET) |->
      TX_EN == $past(TX_RX_SELECT && SHUTDOWN_BAR))
      else $error("transmit enable mismatch");
   chk_rx_enable: assert property (!$past(RESET) |->
      RX_EN == $past(!TX_RX_SELECT && SHUTDOWN_BAR))
      else $error("receive enable mismatch");
   chk_hp_forced: assert property (!$past(RESET) &&
      $past(COUPLING_SELECT) |-> HP_CORNER_SEL == 2'h3)
      else $error("coupling select did not force highpass");
   chk_hp_table: assert property (HP_CORNER_HZ ==
      (HP_CORNER_SEL == 2'h0 ? 20'h00064 : HP_CORNER_SEL == 2'h1 ?
      20'h00fa0 : HP_CORNER_SEL == 2'h2 ? 20'h07530 : 20'h927c0))
      else $error("highpass frequency mismatch");
   chk_rx_trim: assert property (RX_LPF_TRIM_VALID ?
      RX_LPF_TRIM_PCT inside {7'h5a, 7'h5f, 7'h64, 7'h69, 7'h6e} :
      RX_LPF_TRIM_PCT == 7'h64) else $error("receive trim out of set");
   chk_tx_trim: assert property (TX_LPF_TRIM_VALID ?
      TX_LPF_TRIM_PCT inside {7'h5a, 7'h5f, 7'h64, 7'h69, 7'h6e, 7'h73} :
      TX_LPF_TRIM_PCT == 7'h64) else $error("transmit trim out of set");
   chk_corner_pair: assert property ({RX_LPF_CORNER, TX_LPF_CORNER}
      inside {16'h4b50, 16'h556e, 16'h96a5, 16'hb4e1})
      else $error("lowpass corners disagree");
   chk_cm_level: assert property (
      RX_CM_MV inside {11'h44c, 11'h4b0, 11'h514, 11'h578})
      else $error("common mode level out of set");
   chk_strength_gate: assert property (STRENGTH_ON |->
      STRENGTH_SRC != 2'h3 && (STRENGTH_SRC != 2'h0 || RX_EN))
      else $error("strength output on wrongly");
   chk_gain_atten: assert property (TX_ATTEN_HALF_DB == exp_att)
      else $error("transmit attenuation mismatch");
   chk_done_pulse: assert property (WRITE_DONE |->
      !$past(WRITE_DONE) && $past(SER_SEL_N) && $past(SER_SEL_N, 2))
      else $error("write done not a lone pulse after frame");
endmodule
bind radio_filter_gain_mux_control radio_ctrl_monitor mon (
   .REF_CLK(REF_CLK), .RESET(RESET), .SER_SEL_N(SER_SEL_N),
   .COUPLING_SELECT(COUPLING_SELECT), .TX_RX_SELECT(TX_RX_SELECT),
   .SHUTDOWN_BAR(SHUTDOWN_BAR), .WRITE_DONE(WRITE_DONE), .TX_EN(TX_EN),
   .RX_EN(RX_EN), .HP_CORNER_SEL(HP_CORNER_SEL),
   .HP_CORNER_HZ(HP_CORNER_HZ), .RX_LPF_CORNER(RX_LPF_CORNER),
   .RX_LPF_TRIM_PCT(RX_LPF_TRIM_PCT), .RX_LPF_TRIM_VALID(RX_LPF_TRIM_VALID),
   .TX_LPF_CORNER(TX_LPF_CORNER), .TX_LPF_TRIM_PCT(TX_LPF_TRIM_PCT),
   .TX_LPF_TRIM_VALID(TX_LPF_TRIM_VALID), .RX_CM_MV(RX_CM_MV),
   .STRENGTH_SRC(STRENGTH_SRC), .STRENGTH_ON(STRENGTH_ON),
   .TX_GAIN_CODE(TX_GAIN_CODE), .TX_ATTEN_HALF_DB(TX_ATTEN_HALF_DB));
`default_nettype wire

// ==== test/bb_ctrl_model.sv ====
// baseband controller model driving the three-wire serial port
`default_nettype none
module bb_ctrl_model (
   input wire logic clk,
   output logic sel_n,
   output logic sclk,
   output logic sdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sel_n = 1'b1;
      sclk = 1'b0;
      sdata = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // data msb first, then address; short counts exist only for refusals
   task automatic send(input logic [3:0] a, input logic [13:0] d,
                       input int nbits);
      logic [17:0] w;
      w = {d, a};
      sel_n = 1'b0;
      for (int i = 17; i > 17 - nbits; i--) begin
         sdata = w[i];
         hold(2);
         sclk = 1'b1;
         hold(2);
         sclk = 1'b0;
      end
      hold(1);
      sel_n = 1'b1;
      // released line must not keep showing the last bit
      sdata = ~sdata;
   endtask
endmodule
`default_nettype wire

// ==== test/radio_filter_gain_mux_control_tb.sv ====
// self-checking bench for the filter, gain and mux control block
`default_nettype none
module radio_filter_gain_mux_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cpl = 1'b0;
   logic trx = 1'b0;
   logic shutdown_bar_n = 1'b0;
   logic [5:0] gpins = 6'h00;
   logic [6:0] rpins = 7'h00;
   wire logic sel_n, sclk, sdata, done, tx_en, rx_en, rv, tv, s_on;
   wire logic [1:0] hp_sel, s_src, lna;
   wire logic [19:0] hp_hz;
   wire logic [7:0] rx_c, tx_c;
   wire logic [6:0] rx_t, tx_t, att;
   wire logic [10:0] cm;
   wire logic [5:0] gcode;
   wire logic [4:0] vga;
   int fails = 0;
   int tests_run = 0;
   logic [7:0] rxc [4] = '{8'h4b, 8'h55, 8'h96, 8'hb4};
   logic [7:0] txc [4] = '{8'h50, 8'h6e, 8'ha5, 8'he1};
   logic [5:0] gc [5] = '{6'h3f, 6'h30, 6'h2f, 6'h2e, 6'h00};
   logic [6:0] ga [5] = '{7'h00, 7'h0f, 7'h10, 7'h10, 7'h3e};
   always #4 clk = ~clk;
   bb_ctrl_model p (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdata(sdata));
   radio_filter_gain_mux_control uut (.REF_CLK(clk), .RESET(rst),
      .SER_SEL_N(sel_n), .SER_CLK(sclk), .SER_DATA(sdata),
      .COUPLING_SELECT(cpl), .TX_RX_SELECT(trx), .SHUTDOWN_BAR(shutdown_bar_n),
      .PARALLEL_GAIN_PINS(gpins), .RX_GAIN_PINS(rpins), .WRITE_DONE(done),
      .TX_EN(tx_en), .RX_EN(rx_en), .HP_CORNER_SEL(hp_sel),
      .HP_CORNER_HZ(hp_hz), .RX_LPF_CORNER(rx_c), .RX_LPF_TRIM_PCT(rx_t),
      .RX_LPF_TRIM_VALID(rv), .TX_LPF_CORNER(tx_c), .TX_LPF_TRIM_PCT(tx_t),
      .TX_LPF_TRIM_VALID(tv), .RX_CM_MV(cm), .STRENGTH_SRC(s_src),
      .STRENGTH_ON(s_on), .TX_GAIN_CODE(gcode), .TX_ATTEN_HALF_DB(att),
      .RX_LNA_GAIN(lna), .RX_VGA_GAIN(vga));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // bounded wait: a missing write pulse ends the run
   task automatic wr(input logic [3:0] a, input logic [13:0] d,
                     input logic ok, input int nbits = 18);
      logic seen;
      seen = 1'b0;
      p.send(a, d, nbits);
      repeat (8) begin
         tick();
         if (done === 1'b1) seen = 1'b1;
      end
      chk(seen, ok);
      if (ok && !seen) wrap_up();
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_modes();
      for (int i = 0; i < 4; i++) begin
         {trx, shutdown_bar_n} = i[1:0];
         tick();
         chk(tx_en, trx & shutdown_bar_n);
         chk(rx_en, ~trx & shutdown_bar_n);
      end
      $display("test modes done");
   endtask
   task automatic t_hp_trim();
      for (int i = 0; i < 8; i++) begin
         cpl = 1'b0;
         wr(4'h7, {i[1:0], 6'h00, i[2:0], i[2:0]}, 1'b1);
         chk(hp_hz, i[0] ? 20'h00fa0 : i[1] ? 20'h07530 : 20'h64);
         chk(rv, i <= 4);
         chk(rx_t, i <= 4 ? 90 + 5 * i : 100);
         chk(tv, i <= 5);
         chk(tx_t, i <= 5 ? 90 + 5 * i : 100);
         cpl = 1'b1;
         tick();
         chk(hp_hz, 20'h927c0);
      end
      cpl = 1'b0;
      $display("test highpass and trim done");
   endtask
   task automatic t_lpf_mux();
      for (int i = 0; i < 32; i++) begin
         wr(4'h8, {3'h0, i[4], i[3:2], 6'h00, i[1:0]}, 1'b1);
         chk(rx_c, rxc[i[1:0]]);
         chk(tx_c, txc[i[1:0]]);
         chk(s_src, i[3:2]);
         for (int j = 0; j < 2; j++) begin
            cpl = j[0];
            tick();
            chk(s_on, i[3:2] != 3 && (!i[4] || cpl));
         end
      end
      cpl = 1'b0;
      wr(4'h8, 14'h0001, 1'b1);
      trx = 1'b1;
      tick();
      chk(s_on, 1'b0);
      trx = 1'b0;
      tick();
      chk(s_on, 1'b1);
      $display("test lowpass and strength mux done");
   endtask
   task automatic t_cm();
      for (int i = 0; i < 4; i++) begin
         wr(4'hf, {2'h0, i[1:0], 10'h000}, 1'b1);
         chk(cm, 1100 + 100 * i);
      end
      $display("test common mode done");
   endtask
   task automatic t_gain();
      wr(4'h9, 14'h0000, 1'b1);
      for (int k = 0; k < 5; k++) begin
         gpins = gc[k];
         tick();
         chk(gcode, gc[k]);
         chk(att, ga[k]);
      end
      wr(4'hc, 14'h0031, 1'b1);
      wr(4'h9, 14'h0400, 1'b1);
      gpins = 6'h05;
      tick();
      chk(gcode, 6'h31);
      chk(att, 7'h0e);
      rpins = 7'h7f;
      wr(4'h8, 14'h1001, 1'b1);
      wr(4'hb, 14'h0055, 1'b1);
      chk({lna, vga}, 7'h55);
      wr(4'h8, 14'h0001, 1'b1);
      chk({lna, vga}, 7'h7f);
      $display("test gain sources done");
   endtask
   task automatic t_refuse();
      wr(4'h3, 14'h3fff, 1'b0);
      wr(4'h7, 14'h0000, 1'b0, 17);
      chk(hp_hz, 20'h00fa0);
      chk(rx_c, 8'h55);
      $display("test refused frames done");
   endtask
   initial begin
      tick(2);
      rst = 1'b0;
      shutdown_bar_n = 1'b1;
      tick(2);
      chk(rx_c, 8'h55);
      chk(tx_t, 7'h64);
      chk(hp_hz, 20'h00064);
      chk(cm, 11'h44c);
      $display("test reset values done");
      t_modes();
      trx = 1'b0;
      shutdown_bar_n = 1'b1;
      t_hp_trim();
      t_lpf_mux();
      t_cm();
      t_gain();
      t_refuse();
      wrap_up();
   end
endmodule
`default_nettype wire
